// ===== pkg/eepc_pkg.sv
`default_nettype none
package eepc_pkg;
	// ----------------------------------------------------------------
	// Register map (index is word number, byte address is four times it)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_IDX = 8'hf3;
	localparam logic [7:0] PROT_IDX = 8'hf1;
	localparam logic [31:0] CTRL_ADDR = {22'h000000, CTRL_IDX, 2'b00};
	localparam logic [31:0] PROT_ADDR = {22'h000000, PROT_IDX, 2'b00};
	// Array window in bus byte addresses
	localparam logic [15:0] ARR_BASE = 16'h0d00;
	localparam logic [15:0] ARR_LAST = 16'h0fff;
	localparam int ARR_AW = 10;

	// ----------------------------------------------------------------
	// Control register fields and reset value
	// ----------------------------------------------------------------
	localparam int GUARD_BIT = 7;
	localparam int BYTE_BIT = 4;
	localparam int ROW_BIT = 3;
	localparam int ERASE_BIT = 2;
	localparam int LATCH_BIT = 1;
	localparam int PGM_BIT = 0;
	localparam logic [7:0] CTRL_RST = 8'h80;
	localparam logic [7:0] CTRL_RW_MASK = 8'h9f;

	// ----------------------------------------------------------------
	// Protection register fields, reset values and block boundaries
	// ----------------------------------------------------------------
	localparam int LOCK_BIT = 7;
	localparam int LOADED_BIT = 6;
	localparam int BLK_N = 5;
	localparam logic [4:0] BLK_RST = 5'h00;
	localparam logic LOCK_RST = 1'b0;
	localparam logic [9:0] BLK3_START = 10'h100;
	localparam logic [9:0] BLK2_START = 10'h200;
	localparam logic [9:0] BLK1_START = 10'h280;
	localparam logic [9:0] BLK0_START = 10'h2c0;

	// ----------------------------------------------------------------
	// Bus encodings, operations and states
	// ----------------------------------------------------------------
	localparam logic [2:0] SIZE_HALF = 3'h1;
	localparam logic [2:0] SIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_PROG = 3'b001,
		OP_BYTE_ERASE = 3'b010,
		OP_ROW_ERASE = 3'b011,
		OP_BULK_ERASE = 3'b100
	} eepc_op_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ARD = 1'b1
	} eepc_state_t;
endpackage
`default_nettype wire

// ===== pkg/eepc_lat_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Programming latch carrier between control and latch store
// ----------------------------------------------------------------
interface eepc_lat_if;
	logic cap;
	logic clr;
	logic [9:0] cap_addr;
	logic [15:0] cap_data;
	logic cap_word;
	logic loaded;
	logic [9:0] lat_addr;
	logic [15:0] lat_data;
	logic lat_word;
	modport ctrl (output cap, output clr, output cap_addr, output cap_data, output cap_word,
		input loaded, input lat_addr, input lat_data, input lat_word);
	modport store (input cap, input clr, input cap_addr, input cap_data, input cap_word,
		output loaded, output lat_addr, output lat_data, output lat_word);
endinterface
`default_nettype wire

// ===== src/eepc_latch.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Address and data programming latches
// ----------------------------------------------------------------
module eepc_latch (
	input wire logic clk,
	input wire logic rst_n,
	eepc_lat_if.store lat
);
	logic [9:0] addr_q;
	logic [15:0] data_q;
	logic word_q;
	logic loaded_q;

	// Clear wins: disarming throws away a half-finished capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 10'h000;
			data_q <= 16'h0000;
			word_q <= 1'b0;
			loaded_q <= 1'b0;
		end else if (lat.clr) begin
			loaded_q <= 1'b0;
		end else if (lat.cap) begin
			addr_q <= lat.cap_addr;
			data_q <= lat.cap_data;
			word_q <= lat.cap_word;
			loaded_q <= 1'b1;
		end
	end

	assign lat.loaded = loaded_q;
	assign lat.lat_addr = addr_q;
	assign lat.lat_data = data_q;
	assign lat.lat_word = word_q;
endmodule
`default_nettype wire

// ===== src/eepc_top.sv
// What this block does
// - Guard bit set blocks bulk and row erase
// - Guard writable only with voltage off, unlocked
// - Byte and row bits pick erase size
// - Erase bit clear means program, size ignored
// - Byte erase hits only the latched location
// - Erase bit selects mode; frozen while voltage
// - Armed latches make array reads unavailable
// - Mode and arm bits written in any order; here each write not keeping voltage on sets all four, last write wins
// - Voltage enable needs latch arm already set
// - Voltage on freezes guard, mode, arm bits
// - Voltage on ignores array writes, latches fixed
// - Voltage applied exactly while enable bit set
// - Lock bit freezes block guards and guard bit
// - Guarded blocks never programmed or erased
// - Misaligned word latches only the byte at its address
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module eepc_top (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [15:0] ARR_RDATA,
	output logic [9:0] ARR_RADDR,
	output logic PE_VOLTAGE,
	output logic [2:0] ARR_OP,
	output logic [9:0] ARR_ADDR,
	output logic [15:0] ARR_DATA,
	output logic ARR_WORD
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [4:0] blk_q;
	logic [4:0] blk_d;
	logic lock_q;
	logic lock_d;
	logic wr_ctrl_q;
	logic wr_prot_q;
	logic wr_arr_q;
	logic [9:0] wr_off_q;
	logic [2:0] wr_size_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdata_d;
	logic hready_q;
	logic [9:0] raddr_q;
	eepc_pkg::eepc_op_t op_q;
	eepc_pkg::eepc_op_t op_d;
	eepc_pkg::eepc_state_t state_q;
	eepc_lat_if lat ();

	// ----------------------------------------------------------------
	// Address phase decode
	// ----------------------------------------------------------------
	wire a_phase = HSEL & HTRANS[1] & HREADY;
	wire ctrl_hit = (HADDR == eepc_pkg::CTRL_ADDR);
	wire prot_hit = (HADDR == eepc_pkg::PROT_ADDR);
	wire arr_hit = (HADDR[31:16] == 16'h0000) && (HADDR[15:0] >= eepc_pkg::ARR_BASE)
		&& (HADDR[15:0] <= eepc_pkg::ARR_LAST);
	wire [15:0] arr_diff = HADDR[15:0] - eepc_pkg::ARR_BASE;
	wire [9:0] arr_off = arr_diff[9:0];
	wire arr_rd = a_phase & arr_hit & ~HWRITE;
	// Full words have no meaning to a halfword-wide array; every write size except a full word counts
	wire arr_wr_ok = (HSIZE != eepc_pkg::SIZE_WORD);

	// ----------------------------------------------------------------
	// Control register write merge
	// ----------------------------------------------------------------
	wire [7:0] wd = HWDATA[7:0];
	wire pgm_q = ctrl_q[eepc_pkg::PGM_BIT];
	wire arm_q = ctrl_q[eepc_pkg::LATCH_BIT];
	// A write that keeps voltage on leaves every other bit alone
	wire pgm_stays = pgm_q & wd[eepc_pkg::PGM_BIT];
	wire mode_wr = wr_ctrl_q & ~pgm_stays;
	wire guard_wr = wr_ctrl_q & ~pgm_q & ~lock_q;

	// Mode and arm fields are taken together from each write that does not keep voltage on, so the last such write sets all four
	always_comb begin
		ctrl_d = ctrl_q;
		if (mode_wr) begin
			ctrl_d[eepc_pkg::BYTE_BIT] = wd[eepc_pkg::BYTE_BIT];
			ctrl_d[eepc_pkg::ROW_BIT] = wd[eepc_pkg::ROW_BIT];
			ctrl_d[eepc_pkg::ERASE_BIT] = wd[eepc_pkg::ERASE_BIT];
			ctrl_d[eepc_pkg::LATCH_BIT] = wd[eepc_pkg::LATCH_BIT];
		end
		if (guard_wr) begin
			ctrl_d[eepc_pkg::GUARD_BIT] = wd[eepc_pkg::GUARD_BIT];
		end
		if (wr_ctrl_q) begin
			// Arm must already be set before this write; setting both leaves voltage off
			ctrl_d[eepc_pkg::PGM_BIT] = wd[eepc_pkg::PGM_BIT] & arm_q;
		end
		ctrl_d = ctrl_d & eepc_pkg::CTRL_RW_MASK;
	end

	// Protection register: block guards follow the guard bit's write gate
	assign blk_d = (wr_prot_q & ~pgm_q & ~lock_q) ? HWDATA[4:0] : blk_q;
	// Lock only sets; reset is the only way out
	assign lock_d = lock_q | (wr_prot_q & HWDATA[eepc_pkg::LOCK_BIT]);

	// ----------------------------------------------------------------
	// Latch capture (data phase of an array write)
	// ----------------------------------------------------------------
	wire [15:0] lane_half = wr_off_q[1] ? HWDATA[31:16] : HWDATA[15:0];
	wire [7:0] lane_byte = wr_off_q[0] ? lane_half[15:8] : lane_half[7:0];
	// Odd halfword start degrades to a byte at that address
	wire cap_word = (wr_size_q == eepc_pkg::SIZE_HALF) & ~wr_off_q[0];
	// Re-arming while arm stays set lets software load the next location
	assign lat.cap = wr_arr_q & arm_q & ~pgm_q;
	assign lat.clr = arm_q & ~ctrl_d[eepc_pkg::LATCH_BIT];
	assign lat.cap_addr = wr_off_q;
	assign lat.cap_word = cap_word;
	assign lat.cap_data = cap_word ? lane_half : {8'h00, lane_byte};

	eepc_latch eepc_latch_inst (
		.clk(CLK),
		.rst_n(RSTN),
		.lat(lat.store)
	);

	// ----------------------------------------------------------------
	// Block guard lookup for the latched address
	// ----------------------------------------------------------------
	wire [9:0] la = lat.lat_addr;
	wire blk_hit = (la < eepc_pkg::BLK3_START) ? blk_q[4] :
		(la < eepc_pkg::BLK2_START) ? blk_q[3] :
		(la < eepc_pkg::BLK1_START) ? blk_q[2] :
		(la < eepc_pkg::BLK0_START) ? blk_q[1] : blk_q[0];
	wire any_blk = |blk_q;

	// ----------------------------------------------------------------
	// Operation select, aligned with the voltage bit
	// ----------------------------------------------------------------
	wire go = ctrl_d[eepc_pkg::PGM_BIT] & lat.loaded;
	wire ers = ctrl_d[eepc_pkg::ERASE_BIT];
	wire byt = ctrl_d[eepc_pkg::BYTE_BIT];
	wire row = ctrl_d[eepc_pkg::ROW_BIT];
	wire grd = ctrl_d[eepc_pkg::GUARD_BIT];

	always_comb begin
		op_d = eepc_pkg::OP_NONE;
		if (go && !ers) begin
			// Size bits do not matter when programming
			op_d = eepc_pkg::OP_PROG;
		end else if (go && byt) begin
			op_d = eepc_pkg::OP_BYTE_ERASE;
		end else if (go && !grd && row) begin
			op_d = eepc_pkg::OP_ROW_ERASE;
		end else if (go && !grd && !any_blk) begin
			// Whole-array erase would cross every block, so any guard stops it
			op_d = eepc_pkg::OP_BULK_ERASE;
		end
		// A guarded block under the latched address cancels a local operation
		if (blk_hit && (op_d != eepc_pkg::OP_BULK_ERASE)) begin
			op_d = eepc_pkg::OP_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Read data select (register reads see this cycle's write)
	// ----------------------------------------------------------------
	wire [7:0] prot_rd = {lock_d, lat.loaded, 1'b0, blk_d};
	always_comb begin
		rdata_d = 32'h00000000;
		if (ctrl_hit) begin
			rdata_d = {24'h000000, ctrl_d};
		end else if (prot_hit) begin
			rdata_d = {24'h000000, prot_rd};
		end
	end

	// ----------------------------------------------------------------
	// Register and bus state
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q <= eepc_pkg::CTRL_RST;
			blk_q <= eepc_pkg::BLK_RST;
			lock_q <= eepc_pkg::LOCK_RST;
			op_q <= eepc_pkg::OP_NONE;
		end else begin
			ctrl_q <= ctrl_d;
			blk_q <= blk_d;
			lock_q <= lock_d;
			op_q <= op_d;
		end
	end

	// Address phase capture for the following data phase
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_ctrl_q <= 1'b0;
			wr_prot_q <= 1'b0;
			wr_arr_q <= 1'b0;
			wr_off_q <= 10'h000;
			wr_size_q <= 3'h0;
		end else begin
			wr_ctrl_q <= a_phase & HWRITE & ctrl_hit;
			wr_prot_q <= a_phase & HWRITE & prot_hit;
			wr_arr_q <= a_phase & HWRITE & arr_hit & arr_wr_ok;
			wr_off_q <= arr_off;
			wr_size_q <= HSIZE;
		end
	end

	// Array reads take one wait state so the address reaches the array from a flop
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= eepc_pkg::ST_IDLE;
			hready_q <= 1'b1;
			hrdata_q <= 32'h00000000;
			raddr_q <= 10'h000;
		end else begin
			case (state_q)
				eepc_pkg::ST_IDLE: begin
					if (arr_rd && !ctrl_d[eepc_pkg::LATCH_BIT]) begin
						state_q <= eepc_pkg::ST_ARD;
						hready_q <= 1'b0;
						raddr_q <= {arr_off[9:1], 1'b0};
					end else if (arr_rd) begin
						hrdata_q <= 32'h00000000;
					end else if (a_phase && !HWRITE) begin
						hrdata_q <= rdata_d;
					end
				end
				eepc_pkg::ST_ARD: begin
					state_q <= eepc_pkg::ST_IDLE;
					hready_q <= 1'b1;
					hrdata_q <= {ARR_RDATA, ARR_RDATA};
				end
				default: begin
					state_q <= eepc_pkg::ST_IDLE;
					hready_q <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign HRDATA = hrdata_q;
	assign HREADYOUT = hready_q;
	assign HRESP = 1'b0;
	assign ARR_RADDR = raddr_q;
	assign PE_VOLTAGE = ctrl_q[eepc_pkg::PGM_BIT];
	assign ARR_OP = op_q;
	assign ARR_ADDR = lat.lat_addr;
	assign ARR_DATA = lat.lat_data;
	assign ARR_WORD = lat.lat_word;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	sequence blocked_read_s;
		arr_rd && ctrl_d[eepc_pkg::LATCH_BIT];
	endsequence
	sequence pgm_held_s;
		ctrl_q[eepc_pkg::PGM_BIT] ##1 ctrl_q[eepc_pkg::PGM_BIT];
	endsequence
	sequence ctrl_read_s;
		a_phase && !HWRITE && ctrl_hit ##1 HREADYOUT;
	endsequence

	pgm_needs_arm_a: assert property ($rose(ctrl_q[eepc_pkg::PGM_BIT]) |-> $past(arm_q))
		else $error("voltage enable rose without latch arm set");
	frozen_bits_a: assert property (pgm_held_s |-> $stable(ctrl_q[7:1]))
		else $error("guard, mode or arm changed while voltage on");
	guard_lock_a: assert property (lock_q |=> $stable(ctrl_q[eepc_pkg::GUARD_BIT]) && $stable(blk_q))
		else $error("guard bits changed while locked");
	op_voltage_a: assert property (ARR_OP != eepc_pkg::OP_NONE |-> PE_VOLTAGE)
		else $error("array operation without voltage");
	bulk_guard_a: assert property (ctrl_q[eepc_pkg::GUARD_BIT] |-> ARR_OP != eepc_pkg::OP_ROW_ERASE
		&& ARR_OP != eepc_pkg::OP_BULK_ERASE)
		else $error("row or bulk erase while guard set");
	program_mode_a: assert property (ARR_OP != eepc_pkg::OP_NONE && !ctrl_q[eepc_pkg::ERASE_BIT]
		|-> ARR_OP == eepc_pkg::OP_PROG)
		else $error("erase issued in program mode");
	row_select_a: assert property (ARR_OP == eepc_pkg::OP_ROW_ERASE
		|-> !ctrl_q[eepc_pkg::BYTE_BIT] && ctrl_q[eepc_pkg::ROW_BIT])
		else $error("row erase with wrong size bits");
	read_block_a: assert property (blocked_read_s |=> HREADYOUT && HRDATA == 32'h00000000)
		else $error("array read returned data while armed");
	latch_hold_a: assert property (ctrl_q[eepc_pkg::PGM_BIT] |=> $stable(ARR_ADDR) && $stable(ARR_DATA))
		else $error("latched address or data moved while voltage on");
	block_guard_a: assert property (ARR_OP == eepc_pkg::OP_PROG |-> !blk_hit)
		else $error("program issued into a guarded block");
	reserved_zero_a: assert property (ctrl_read_s |-> HRDATA[6:5] == 2'b00)
		else $error("reserved control bits read nonzero");
endmodule
`default_nettype wire

// ===== bench/eepc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module eepc_tb_top;
	// ----------------------------------------------------------------
	// Signals, clock and the array macro stand-in
	// ----------------------------------------------------------------
	logic clk, rstn, hsel, hwrite, hreadyout, hresp, pe_voltage, arr_word;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize, arr_op;
	logic [15:0] arr_rdata, arr_data;
	logic [9:0] arr_raddr, arr_addr;
	int n_fail, tests_run, cyc;
	localparam logic [31:0] CA = eepc_pkg::CTRL_ADDR;
	localparam logic [31:0] PA = eepc_pkg::PROT_ADDR;
	localparam logic [31:0] AB = 32'h00000d00;
	localparam logic [7:0] MD [6] = '{8'h86, 8'h8e, 8'h06, 8'h0e, 8'h16, 8'h1e};
	localparam logic [2:0] OPS [6] = '{3'h0, 3'h0, 3'h4, 3'h3, 3'h2, 3'h2};

	always #5 clk = ~clk;
	// Read data depends on the offset so a wrong offset shows up
	assign arr_rdata = {6'h15, arr_raddr};

	eepc_top eepc_top_inst (.CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.ARR_RDATA(arr_rdata), .ARR_RADDR(arr_raddr), .PE_VOLTAGE(pe_voltage),
		.ARR_OP(arr_op), .ARR_ADDR(arr_addr), .ARR_DATA(arr_data), .ARR_WORD(arr_word));

	// ----------------------------------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------------------------------
	// Called just after a rising edge; ready and read data are taken at the edge they stand
	task bus(input logic w, input logic [31:0] a, input logic [2:0] sz,
		input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz);
		logic [31:0] x;
		bus(1'b1, a, sz, d, x);
	endtask

	task rdc(input logic [31:0] a, input logic [31:0] e, input string m);
		logic [31:0] x;
		bus(1'b0, a, 3'h2, 32'h00000000, x);
		cmp(x, e, m);
	endtask

	// Array-side outputs, taken at the next edge after the write has stood a cycle
	task outs(input logic v, input logic [2:0] op, input logic wd, input logic [9:0] ad,
		input logic [15:0] dt, input string m);
		@(posedge clk);
		cmp({1'b0, pe_voltage, arr_op, arr_word, arr_addr, arr_data}, {1'b0, v, op, wd, ad, dt}, m);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rdc(CA, 32'h00000080, "ctrl reset");
		rdc(PA, 32'h00000000, "prot reset");
		wr(32'h000003c8, 32'h000000ff, 3'h2);
		rdc(32'h000003c8, 32'h00000000, "unmapped");
		$display("t_reset done");
	endtask

	task t_bits;
		wr(CA, 32'h0000007f, 3'h2);
		rdc(CA, 32'h0000001e, "guard clear, rsvd zero, no pgm");
		wr(CA, 32'h00000000, 3'h2);
		wr(CA, 32'h0000001c, 3'h2);
		wr(CA, 32'h00000002, 3'h2);
		rdc(CA, 32'h00000002, "arm alone");
		wr(CA, 32'h0000009e, 3'h2);
		rdc(CA, 32'h0000009e, "all at once");
		wr(CA, 32'h00000080, 3'h2);
		$display("t_bits done");
	endtask

	task t_prog;
		wr(CA, 32'h0000009a, 3'h2);
		rdc(AB + 32'h10, 32'h00000000, "read while armed");
		wr(AB + 32'h10, 32'h0000005a, 3'h0);
		wr(CA, 32'h0000009b, 3'h2);
		outs(1'b1, 3'h1, 1'b0, 10'h010, 16'h005a, "program");
		wr(AB + 32'h14, 32'h00000077, 3'h0);
		wr(CA, 32'h0000001d, 3'h2);
		rdc(CA, 32'h0000009b, "frozen with voltage");
		outs(1'b1, 3'h1, 1'b0, 10'h010, 16'h005a, "latch fixed");
		wr(CA, 32'h00000000, 3'h2);
		@(posedge clk);
		cmp({28'h0, pe_voltage, arr_op}, 32'h0, "voltage off");
		rdc(CA, 32'h00000080, "guard kept");
		rdc(AB + 32'h10, {2{16'h5410}}, "normal read");
		$display("t_prog done");
	endtask

	// Guard set first refuses bulk and row, then each size with guard clear
	task t_erase;
		for (int i = 0; i < 6; i++) begin
			wr(CA, {24'h0, MD[i] | 8'h02}, 3'h2);
			wr(AB + 32'h40, 32'h00000011, 3'h0);
			wr(CA, {24'h0, MD[i] | 8'h03}, 3'h2);
			outs(1'b1, OPS[i], 1'b0, 10'h040, 16'h0011, "erase mode");
			wr(CA, {24'h0, MD[i] & 8'h80}, 3'h2);
		end
		$display("t_erase done");
	endtask

	task t_word;
		wr(CA, 32'h00000016, 3'h2);
		wr(AB + 32'h42, 32'hbeef0000, eepc_pkg::SIZE_HALF);
		wr(CA, 32'h00000017, 3'h2);
		outs(1'b1, 3'h2, 1'b1, 10'h042, 16'hbeef, "word erase");
		wr(CA, 32'h00000016, 3'h2);
		rdc(CA, 32'h00000016, "arm kept");
		wr(AB + 32'h41, 32'h0000c300, eepc_pkg::SIZE_HALF);
		wr(CA, 32'h00000017, 3'h2);
		outs(1'b1, 3'h2, 1'b0, 10'h041, 16'h00c3, "misaligned word");
		wr(CA, 32'h00000000, 3'h2);
		$display("t_word done");
	endtask

	task t_block;
		wr(PA, 32'h00000001, 3'h2);
		wr(CA, 32'h00000002, 3'h2);
		wr(AB + 32'h2c0, 32'h00000033, 3'h0);
		wr(CA, 32'h00000003, 3'h2);
		outs(1'b1, 3'h0, 1'b0, 10'h2c0, 16'h0033, "guarded block");
		wr(CA, 32'h00000002, 3'h2);
		wr(AB + 32'h20, 32'h00000033, 3'h0);
		wr(CA, 32'h00000003, 3'h2);
		outs(1'b1, 3'h1, 1'b0, 10'h020, 16'h0033, "open block");
		wr(CA, 32'h00000000, 3'h2);
		wr(PA, 32'h00000081, 3'h2);
		wr(PA, 32'h00000000, 3'h2);
		rdc(PA, 32'h00000081, "lock freezes blocks");
		wr(CA, 32'h00000080, 3'h2);
		rdc(CA, 32'h00000000, "lock freezes guard");
		$display("t_block done");
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Whole run is under a hundred transfers; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			$display("[FAIL] %0t timeout", $time);
			stop_test;
		end
	end

	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		n_fail = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_bits;
		t_prog;
		t_erase;
		t_word;
		t_block;
		stop_test;
	end
endmodule
`default_nettype wire
